// ==== core/hpd_defs.svh ====
// Address decode constants for the second bridge address map.
// Assumes inclusion by the map decoder module, its only user.
`ifndef HPD_DEFS_SVH
`define HPD_DEFS_SVH
// Processor-side windows
`define HPD_C_SYS0_LO   32'h0000_0000
`define HPD_C_SYS0_HI   32'h0009_ffff
`define HPD_C_HOLE_LO   32'h000a_0000
`define HPD_C_HOLE_HI   32'h000b_ffff
`define HPD_C_SYS1_LO   32'h000c_0000
`define HPD_C_SYS1_HI   32'h3fff_ffff
`define HPD_RSV_LO      32'h4000_0000
`define HPD_RSV_HI      32'h7fff_ffff
`define HPD_PMEM_LO     32'h8000_0000
`define HPD_PMEM_HI     32'hfcff_ffff
`define HPD_ISAM_LO     32'hfd00_0000
`define HPD_ISAM_HI     32'hfdff_ffff
`define HPD_ISAIO_LO    32'hfe00_0000
`define HPD_ISAIO_HI    32'hfe7f_ffff
`define HPD_ISAIO_CHI   32'hfe00_ffff
`define HPD_PIO_LO      32'hfe80_0000
`define HPD_PIO_HI      32'hfebf_ffff
`define HPD_CFGA_LO     32'hfec0_0000
`define HPD_CFGA_HI     32'hfedf_ffff
`define HPD_CFGD_LO     32'hfee0_0000
`define HPD_CFGD_HI     32'hfeef_ffff
`define HPD_IACK_LO     32'hfef0_0000
`define HPD_IACK_HI     32'hfeff_ffff
`define HPD_ROM64_LO    32'hff00_0000
`define HPD_ROM64_HI    32'hff7f_ffff
`define HPD_ROM8_LO     32'hff80_0000
`define HPD_ROM8_HI     32'hffff_ffff
// PCI memory-side windows
`define HPD_P_HOLE_HI   32'h000f_ffff
`define HPD_P_SYS1_LO   32'h0010_0000
`define HPD_P_RSVH_LO   32'hfe00_0000
`define HPD_P_RSVH_HI   32'hfeff_ffff
// PCI I/O-side windows
`define HPD_IO_ISA_HI   32'h0000_ffff
`define HPD_IO_PIO_LO   32'h0080_0000
`define HPD_IO_PIO_HI   32'h00bf_ffff
// Reset and strap values, timing
`define HPD_MAP_B       1'b0
`define HPD_ALL_ONES    32'hffff_ffff
`define HPD_STRAP_WAIT  2'h3
`endif

// ==== core/hpd_pkg.sv ====
// Types shared by the map decoder modules.
// Assumes the constants header sits beside it.
package hpd_pkg;
  typedef enum logic [8:0] {
    TGT_NONE    = 9'h001,
    TGT_SYSMEM  = 9'h002,
    TGT_PCIMEM  = 9'h004,
    TGT_PCIIO   = 9'h008,
    TGT_CFGADDR = 9'h010,
    TGT_CFGDATA = 9'h020,
    TGT_INTACK  = 9'h040,
    TGT_ROM     = 9'h080,
    TGT_RSV     = 9'h100
  } hpd_target_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'h1,
    ST_RUN    = 2'h2
  } hpd_state_t;

  typedef struct packed {
    hpd_target_t target;
    logic [31:0] pciAddr;
    logic        memSelErr;
    logic        readAllOnes;
    logic        writeDiscard;
    logic        transferErrorAck;
    logic        romLocal;
    logic        romToPci;
    logic        rom64Only;
  } hpd_cpu_result_t;

  typedef struct packed {
    logic        claim;
    logic        toRom;
    logic [31:0] sysAddr;
    logic        memSelErr;
    logic        ioReserved;
    logic        rom64Only;
  } hpd_pci_result_t;
endpackage

// ==== core/hpd_range_check.sv ====
// Inclusive address window compare.
// Assumes a 32-bit byte address; pure combinational.
`timescale 1ns/10ps
module hpd_range_check #(
  parameter logic [31:0] LO = 32'h0000_0000,
  parameter logic [31:0] HI = 32'hffff_ffff
) (
  input  wire logic [31:0] addr,
  output logic             hit
);
  // Both bounds inclusive, as every window is printed
  assign hit = (addr >= LO) && (addr <= HI);
endmodule

// ==== core/hpd_map_b.sv ====
// Second address map decoder: processor and PCI-master address steering.
// Assumes requests are synchronous to clock; strap pin is asynchronous.
`timescale 1ns/10ps
`include "hpd_defs.svh"

// Notes on behaviour
// - While this map is active, classify every address into one area or window.
// - Processor low memory outside the hole goes to system memory, no PCI cycle.
// - Hole goes to system or PCI memory by separate processor and PCI settings.
// - Reserved 40000000-7FFFFFFF raises memory select error when enabled.
// - Error detection off: reserved reads return ones, writes are dropped.
// - Processor 80000000-FCFFFFFF goes to PCI memory unchanged.
// - FD window goes to PCI memory with upper byte zeroed.
// - Contiguous I/O window uses low 24 bits; FE010000-FE7FFFFF reserved.
// - Discontiguous I/O address is zero, then bits 22..12, then bits 4..0.
// - FE800000-FEBFFFFF goes to PCI I/O with upper byte cleared.
// - FEC00000-FEDFFFFF aliases to the configuration address port.
// - FEE00000-FEEFFFFF aliases to the configuration data port.
// - Reads in FEF window run an interrupt acknowledge cycle.
// - Writes in FEF window raise transfer error ack when enabled.
// - FF000000-FF7FFFFF is 64-bit ROM, rest 8 or 64-bit, same PCI address.
// - ROM may live on processor bus, PCI, or both; steer accordingly.
// - PCI memory low and 1M-1G areas claimed for system memory, same address.
// - PCI memory 80000000-FCFFFFFF and FE window are never claimed.
// - With alias enable, PCI FD window claimed with upper byte cleared.
// - PCI memory FF window maps to ROM, same address.
// - PCI I/O never claimed; flags reserved I/O areas.
// - Strap at reset picks the map, zero selects this one; software may change.
module hpd_map_b
  import hpd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        boot_map_strap,
  input  wire logic        mapSelWrite,
  input  wire logic        mapSelValue,
  input  wire logic        memSelErrEnable,
  input  wire logic        teaEnable,
  input  wire logic        cpu_side_hole_route,
  input  wire logic        pciSideHoleRoute,
  input  wire logic        low_memory_alias_enable,
  input  wire logic        io_contiguity_select,
  input  wire logic        romOnCpuBus,
  input  wire logic        romOnPci,
  input  wire logic        cpuReq,
  input  wire logic        cpuWrite,
  input  wire logic [31:0] cpuAddr,
  input  wire logic        pciReq,
  input  wire logic        pciIsIo,
  input  wire logic [31:0] pciAddr,
  output logic             mapBActive,
  output logic             strapDone,
  output logic             cpuDone,
  output hpd_cpu_result_t  cpuResult,
  output logic             pciDone,
  output hpd_pci_result_t  pciResult
);

  // Reset release through two flops
  logic rstMeta_reg;
  logic rstLocal_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstLocal_n  <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstLocal_n  <= rstMeta_reg;
    end
  end

  // Strap synchroniser: three stages, second and third must agree
  logic strapS1_reg;
  logic strapS2_reg;
  logic strapS3_reg;
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      strapS1_reg <= 1'b1;
      strapS2_reg <= 1'b1;
      strapS3_reg <= 1'b1;
    end else begin
      strapS1_reg <= boot_map_strap;
      strapS2_reg <= strapS1_reg;
      strapS3_reg <= strapS2_reg;
    end
  end

  // Strap capture sequence; waits for the synchroniser to fill
  hpd_state_t state_reg;
  hpd_state_t state_next;
  logic [1:0] settle_reg;
  logic       capture;
  always_comb begin
    state_next = state_reg;
    capture    = 1'b0;
    case (state_reg)
      ST_SETTLE: begin
        if (settle_reg == `HPD_STRAP_WAIT && strapS2_reg == strapS3_reg) begin
          capture    = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      state_reg  <= ST_SETTLE;
      settle_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (settle_reg != `HPD_STRAP_WAIT) begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // Map select: strap first, software after; zero selects this map
  logic mapSel_reg;
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      mapSel_reg <= `HPD_MAP_B;
    end else if (capture) begin
      mapSel_reg <= strapS3_reg;
    end else if (mapSelWrite && state_reg == ST_RUN) begin
      mapSel_reg <= mapSelValue;
    end
  end
  assign mapBActive = (mapSel_reg == `HPD_MAP_B) && (state_reg == ST_RUN);
  assign strapDone  = (state_reg == ST_RUN);

  // Processor-side window hits
  logic cSys0, cHole, cSys1, cRsv, cPmem, cIsaM, cIsaIo, cIsaC;
  logic cPio, cCfgA, cCfgD, cIack, cRom64, cRom8;
  hpd_range_check #(.LO(`HPD_C_SYS0_LO), .HI(`HPD_C_SYS0_HI)) uCSys0 (
    .addr(cpuAddr),
    .hit (cSys0)
  );
  hpd_range_check #(.LO(`HPD_C_HOLE_LO), .HI(`HPD_C_HOLE_HI)) uCHole (
    .addr(cpuAddr),
    .hit (cHole)
  );
  hpd_range_check #(.LO(`HPD_C_SYS1_LO), .HI(`HPD_C_SYS1_HI)) uCSys1 (
    .addr(cpuAddr),
    .hit (cSys1)
  );
  hpd_range_check #(.LO(`HPD_RSV_LO), .HI(`HPD_RSV_HI)) uCRsv (
    .addr(cpuAddr),
    .hit (cRsv)
  );
  hpd_range_check #(.LO(`HPD_PMEM_LO), .HI(`HPD_PMEM_HI)) uCPmem (
    .addr(cpuAddr),
    .hit (cPmem)
  );
  hpd_range_check #(.LO(`HPD_ISAM_LO), .HI(`HPD_ISAM_HI)) uCIsaM (
    .addr(cpuAddr),
    .hit (cIsaM)
  );
  hpd_range_check #(.LO(`HPD_ISAIO_LO), .HI(`HPD_ISAIO_HI)) uCIsaIo (
    .addr(cpuAddr),
    .hit (cIsaIo)
  );
  hpd_range_check #(.LO(`HPD_ISAIO_LO), .HI(`HPD_ISAIO_CHI)) uCIsaC (
    .addr(cpuAddr),
    .hit (cIsaC)
  );
  hpd_range_check #(.LO(`HPD_PIO_LO), .HI(`HPD_PIO_HI)) uCPio (
    .addr(cpuAddr),
    .hit (cPio)
  );
  hpd_range_check #(.LO(`HPD_CFGA_LO), .HI(`HPD_CFGA_HI)) uCCfgA (
    .addr(cpuAddr),
    .hit (cCfgA)
  );
  hpd_range_check #(.LO(`HPD_CFGD_LO), .HI(`HPD_CFGD_HI)) uCCfgD (
    .addr(cpuAddr),
    .hit (cCfgD)
  );
  hpd_range_check #(.LO(`HPD_IACK_LO), .HI(`HPD_IACK_HI)) uCIack (
    .addr(cpuAddr),
    .hit (cIack)
  );
  hpd_range_check #(.LO(`HPD_ROM64_LO), .HI(`HPD_ROM64_HI)) uCRom64 (
    .addr(cpuAddr),
    .hit (cRom64)
  );
  hpd_range_check #(.LO(`HPD_ROM8_LO), .HI(`HPD_ROM8_HI)) uCRom8 (
    .addr(cpuAddr),
    .hit (cRom8)
  );

  // Processor decode; one window hits at a time, so chain order is free
  hpd_cpu_result_t cpuNext;
  always_comb begin
    cpuNext         = '0;
    cpuNext.target  = TGT_NONE;
    cpuNext.pciAddr = cpuAddr;
    if (!mapBActive) begin
      cpuNext.target = TGT_NONE;
    end else if (cSys0 || cSys1) begin
      cpuNext.target = TGT_SYSMEM;
    end else if (cHole) begin
      // Hole setting one keeps it in system memory
      cpuNext.target = cpu_side_hole_route ? TGT_SYSMEM : TGT_PCIMEM;
    end else if (cRsv) begin
      cpuNext.target       = TGT_RSV;
      cpuNext.memSelErr    = memSelErrEnable;
      cpuNext.readAllOnes  = !memSelErrEnable && !cpuWrite;
      cpuNext.writeDiscard = !memSelErrEnable && cpuWrite;
    end else if (cPmem) begin
      cpuNext.target = TGT_PCIMEM;
    end else if (cIsaM) begin
      cpuNext.target  = TGT_PCIMEM;
      cpuNext.pciAddr = {8'h00, cpuAddr[23:0]};
    end else if (cIsaIo) begin
      cpuNext.target = TGT_PCIIO;
      if (io_contiguity_select) begin
        // Spreads each 32-byte block onto its own 4-Kbyte page
        cpuNext.pciAddr = {16'h0000, cpuAddr[22:12], cpuAddr[4:0]};
      end else if (cIsaC) begin
        cpuNext.pciAddr = {8'h00, cpuAddr[23:0]};
      end else begin
        cpuNext.target       = TGT_RSV;
        cpuNext.readAllOnes  = !cpuWrite;
        cpuNext.writeDiscard = cpuWrite;
      end
    end else if (cPio) begin
      cpuNext.target  = TGT_PCIIO;
      cpuNext.pciAddr = {8'h00, cpuAddr[23:0]};
    end else if (cCfgA) begin
      cpuNext.target = TGT_CFGADDR;
    end else if (cCfgD) begin
      cpuNext.target = TGT_CFGDATA;
    end else if (cIack) begin
      cpuNext.target = TGT_INTACK;
      // Writes carry no acknowledge cycle; error only if enabled
      cpuNext.transferErrorAck = cpuWrite && teaEnable;
      cpuNext.writeDiscard     = cpuWrite && !teaEnable;
    end else if (cRom64 || cRom8) begin
      cpuNext.target    = TGT_ROM;
      cpuNext.rom64Only = cRom64;
      cpuNext.romLocal  = romOnCpuBus;
      cpuNext.romToPci  = romOnPci;
    end
  end

  // PCI-side window hits
  logic pSys0, pHole, pSys1, pRsv, pPmem, pFd, pRsvH, pRom64, pRom8;
  logic ioIsa, ioPio;
  hpd_range_check #(.LO(`HPD_C_SYS0_LO), .HI(`HPD_C_SYS0_HI)) uPSys0 (
    .addr(pciAddr),
    .hit (pSys0)
  );
  hpd_range_check #(.LO(`HPD_C_HOLE_LO), .HI(`HPD_P_HOLE_HI)) uPHole (
    .addr(pciAddr),
    .hit (pHole)
  );
  hpd_range_check #(.LO(`HPD_P_SYS1_LO), .HI(`HPD_C_SYS1_HI)) uPSys1 (
    .addr(pciAddr),
    .hit (pSys1)
  );
  hpd_range_check #(.LO(`HPD_RSV_LO), .HI(`HPD_RSV_HI)) uPRsv (
    .addr(pciAddr),
    .hit (pRsv)
  );
  hpd_range_check #(.LO(`HPD_PMEM_LO), .HI(`HPD_PMEM_HI)) uPPmem (
    .addr(pciAddr),
    .hit (pPmem)
  );
  hpd_range_check #(.LO(`HPD_ISAM_LO), .HI(`HPD_ISAM_HI)) uPFd (
    .addr(pciAddr),
    .hit (pFd)
  );
  hpd_range_check #(.LO(`HPD_P_RSVH_LO), .HI(`HPD_P_RSVH_HI)) uPRsvH (
    .addr(pciAddr),
    .hit (pRsvH)
  );
  hpd_range_check #(.LO(`HPD_ROM64_LO), .HI(`HPD_ROM64_HI)) uPRom64 (
    .addr(pciAddr),
    .hit (pRom64)
  );
  hpd_range_check #(.LO(`HPD_ROM8_LO), .HI(`HPD_ROM8_HI)) uPRom8 (
    .addr(pciAddr),
    .hit (pRom8)
  );
  hpd_range_check #(.LO(`HPD_C_SYS0_LO), .HI(`HPD_IO_ISA_HI)) uIoIsa (
    .addr(pciAddr),
    .hit (ioIsa)
  );
  hpd_range_check #(.LO(`HPD_IO_PIO_LO), .HI(`HPD_IO_PIO_HI)) uIoPio (
    .addr(pciAddr),
    .hit (ioPio)
  );

  // PCI decode; claim means the bridge answers as target
  hpd_pci_result_t pciNext;
  always_comb begin
    pciNext         = '0;
    pciNext.sysAddr = pciAddr;
    if (!mapBActive) begin
      pciNext.claim = 1'b0;
    end else if (pciIsIo) begin
      // I/O is only ever passed to other targets
      pciNext.claim      = 1'b0;
      pciNext.ioReserved = !(ioIsa || ioPio);
    end else if (pSys0 || pSys1) begin
      pciNext.claim = 1'b1;
    end else if (pHole) begin
      pciNext.claim = pciSideHoleRoute;
    end else if (pRsv) begin
      // Claimed so the error or all-ones answer has an owner
      pciNext.claim     = 1'b1;
      pciNext.memSelErr = memSelErrEnable;
    end else if (pPmem || pRsvH) begin
      pciNext.claim = 1'b0;
    end else if (pFd) begin
      pciNext.claim   = low_memory_alias_enable;
      pciNext.sysAddr = {8'h00, pciAddr[23:0]};
    end else if (pRom64 || pRom8) begin
      // Only a ROM on the local bus can be claimed from PCI
      pciNext.claim     = romOnCpuBus;
      pciNext.toRom     = 1'b1;
      pciNext.rom64Only = pRom64;
    end
  end

  // Processor answer register; one cycle after the request
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      cpuDone   <= 1'b0;
      cpuResult <= '{target: TGT_NONE, default: '0};
    end else begin
      cpuDone <= cpuReq;
      if (cpuReq) begin
        cpuResult <= cpuNext;
      end
    end
  end

  // PCI answer register; one cycle after the request
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pciDone   <= 1'b0;
      pciResult <= '0;
    end else begin
      pciDone <= pciReq;
      if (pciReq) begin
        pciResult <= pciNext;
      end
    end
  end

endmodule

// ==== bench/hpd_map_b_checker.sv ====
// Port-level assertions for the second map decoder.
// Assumes binding onto hpd_map_b; one clock domain.
`timescale 1ns/10ps
module hpd_map_b_checker
  import hpd_pkg::*;
(
  input wire logic            clock,
  input wire logic            rst_n,
  input wire logic            strapDone,
  input wire logic            mapBActive,
  input wire logic            memSelErrEnable,
  input wire logic            cpuReq,
  input wire logic [31:0]     cpuAddr,
  input wire logic            cpuDone,
  input wire hpd_cpu_result_t cpuResult,
  input wire logic            pciReq,
  input wire logic            pciIsIo,
  input wire logic [31:0]     pciAddr,
  input wire logic            pciDone,
  input wire hpd_pci_result_t pciResult
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Requests decoded while this map is live
  logic cpuLive;
  logic pciMem;
  assign cpuLive = cpuReq && mapBActive;
  assign pciMem  = pciReq && mapBActive && !pciIsIo;
  property p_cpu_ans; strapDone && cpuReq |=> cpuDone; endproperty
  property p_pci_ans; strapDone && pciReq |=> pciDone; endproperty
  property p_sys; cpuLive && cpuAddr < 32'h000a_0000 |=> cpuResult.target == TGT_SYSMEM; endproperty
  property p_rsv; cpuLive && cpuAddr[31:30] == 2'h1 && memSelErrEnable |=> cpuResult.memSelErr; endproperty
  property p_pmem;
    cpuLive && cpuAddr inside {[32'h8000_0000:32'hfcff_ffff]}
      |=> cpuResult.target == TGT_PCIMEM && cpuResult.pciAddr == $past(cpuAddr);
  endproperty
  property p_pio;
    cpuLive && cpuAddr[31:22] == 10'h3fa |=> cpuResult.pciAddr == ($past(cpuAddr) & 32'h00ff_ffff);
  endproperty
  property p_io_none; pciReq && pciIsIo |=> !pciResult.claim; endproperty
  property p_pci_low;
    pciMem && pciAddr < 32'h000a_0000 |=> pciResult.claim && pciResult.sysAddr == $past(pciAddr);
  endproperty
  property p_pci_far;
    pciReq && !pciIsIo && (pciAddr[31:24] == 8'hfe || pciAddr inside {[32'h8000_0000:32'hfcff_ffff]})
      |=> !pciResult.claim;
  endproperty
  a_cpu_ans: assert property (p_cpu_ans) else $error("cpu answer missing");
  a_pci_ans: assert property (p_pci_ans) else $error("pci answer missing");
  a_sys: assert property (p_sys) else $error("low memory not system");
  a_rsv: assert property (p_rsv) else $error("no memory select error");
  a_pmem: assert property (p_pmem) else $error("pci memory address wrong");
  a_pio: assert property (p_pio) else $error("pci io address wrong");
  a_io_none: assert property (p_io_none) else $error("io access claimed");
  a_pci_low: assert property (p_pci_low) else $error("low pci memory not claimed");
  a_pci_far: assert property (p_pci_far) else $error("far pci memory claimed");
  c_err: cover property (cpuDone && cpuResult.memSelErr);
  c_pio: cover property (cpuDone && cpuResult.target == TGT_PCIIO);
  c_claim: cover property (pciDone && pciResult.claim);
  c_off: cover property (strapDone && !mapBActive);
endmodule

bind hpd_map_b hpd_map_b_checker CHK (.clock(clock), .rst_n(rst_n), .strapDone(strapDone),
  .mapBActive(mapBActive), .memSelErrEnable(memSelErrEnable), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
  .cpuDone(cpuDone), .cpuResult(cpuResult), .pciReq(pciReq), .pciIsIo(pciIsIo), .pciAddr(pciAddr),
  .pciDone(pciDone), .pciResult(pciResult));

// ==== bench/hpd_master_model.sv ====
// Processor and PCI master models issuing one-cycle requests.
// Assumes tasks are called from the bench just after a clock edge.
`timescale 1ns/10ps
module hpd_master_model (
  input  wire logic        clock,
  output logic             strapPin,
  output logic             cpuReq,
  output logic             cpuWrite,
  output logic [31:0]      cpuAddr,
  output logic             pciReq,
  output logic             pciIsIo,
  output logic [31:0]      pciAddr
);
  // Board pull-down picks this map at power-on
  assign strapPin = 1'b0;
  // Idle masters
  initial begin
    cpuReq = 1'b0;
    pciReq = 1'b0;
  end
  // Request held to the taking edge; released lines show the inverse, not stale data
  task automatic cpu_cycle(input logic [31:0] a, input logic w);
    @(posedge clock);
    #1;
    cpuReq = 1'b1;
    cpuWrite = w;
    cpuAddr = a;
    @(posedge clock);
    #1;
    cpuReq = 1'b0;
    cpuWrite = ~w;
    cpuAddr = ~a;
  endtask
  task automatic pci_cycle(input logic [31:0] a, input logic io);
    @(posedge clock);
    #1;
    pciReq = 1'b1;
    pciIsIo = io;
    pciAddr = a;
    @(posedge clock);
    #1;
    pciReq = 1'b0;
    pciIsIo = ~io;
    pciAddr = ~a;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the second map decoder.
// Assumes the master model drives requests; bench drives configuration.
`timescale 1ns/10ps
module tb_top
  import hpd_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic mapSelWrite = 1'b0, mapSelValue = 1'b0, memSelErrEnable = 1'b0, teaEnable = 1'b0;
  logic cHole = 1'b0, pHole = 1'b0, fdAlias = 1'b0, ioSel = 1'b0, romCpu = 1'b0, romPci = 1'b0;
  logic strap, cpuReq, cpuWrite, pciReq, pciIsIo, mapBActive, strapDone, cpuDone, pciDone;
  logic [31:0] cpuAddr, pciAddr;
  hpd_cpu_result_t cpuRes;
  hpd_pci_result_t pciRes;
  logic mapOn = 1'b0;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] corner[] = '{32'h0009_ffff, 32'h000a_0000, 32'h000b_ffff, 32'h000c_0000, 32'h000f_ffff,
    32'h0010_0000, 32'h3fff_ffff, 32'h4000_0000, 32'h7fff_ffff, 32'h8000_0000, 32'hfcff_ffff,
    32'hfd00_0000, 32'hfe00_ffff, 32'hfe01_0000, 32'hfe7f_ffff, 32'hfe80_0000, 32'hfebf_ffff,
    32'hfec0_0000, 32'hfee0_0000, 32'hfef0_0000, 32'hff7f_ffff, 32'hff80_0000, 32'h0000_ffff,
    32'h0001_0000, 32'h00bf_ffff, 32'h00c0_0000};
  logic [7:0] tops[] = '{8'h00, 8'h40, 8'h80, 8'hfd, 8'hfe, 8'hfe, 8'hff, 8'hfc};

  // Free-running 25 MHz clock
  always #20 clock = ~clock;

  hpd_master_model BUS (.clock(clock), .strapPin(strap), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
    .cpuAddr(cpuAddr), .pciReq(pciReq), .pciIsIo(pciIsIo), .pciAddr(pciAddr));

  hpd_map_b DUT (.clock(clock), .rst_n(rst_n), .boot_map_strap(strap), .mapSelWrite(mapSelWrite),
    .mapSelValue(mapSelValue), .memSelErrEnable(memSelErrEnable), .teaEnable(teaEnable),
    .cpu_side_hole_route(cHole), .pciSideHoleRoute(pHole), .low_memory_alias_enable(fdAlias),
    .io_contiguity_select(ioSel), .romOnCpuBus(romCpu), .romOnPci(romPci), .cpuReq(cpuReq),
    .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .pciReq(pciReq), .pciIsIo(pciIsIo), .pciAddr(pciAddr),
    .mapBActive(mapBActive), .strapDone(strapDone), .cpuDone(cpuDone), .cpuResult(cpuRes),
    .pciDone(pciDone), .pciResult(pciRes));

  // Expected processor-side decode
  function automatic hpd_cpu_result_t exp_cpu(logic [31:0] a, logic w);
    hpd_cpu_result_t r;
    r = '0;
    r.target = mapOn ? TGT_SYSMEM : TGT_NONE;
    r.pciAddr = a;
    if (!mapOn) return r;
    if (a inside {[32'h000a_0000:32'h000b_ffff]}) r.target = cHole ? TGT_SYSMEM : TGT_PCIMEM;
    else if (a[31:30] == 2'h1) begin
      r.target = TGT_RSV;
      r.memSelErr = memSelErrEnable;
      r.readAllOnes = !memSelErrEnable && !w;
      r.writeDiscard = !memSelErrEnable && w;
    end else if (a[31]) begin
      r.target = TGT_PCIMEM;
      if (a[31:24] == 8'hfd) r.pciAddr = a & 32'h00ff_ffff;
      if (a[31:23] == 9'h1fc) begin
        r.target = TGT_PCIIO;
        r.pciAddr = ioSel ? {16'h0000, a[22:12], a[4:0]} : a & 32'h00ff_ffff;
        if (!ioSel && a[22:16] != 7'h00) begin
          r.target = TGT_RSV;
          r.readAllOnes = !w;
          r.writeDiscard = w;
        end
      end
      if (a[31:22] == 10'h3fa) begin
        r.target = TGT_PCIIO;
        r.pciAddr = a & 32'h00ff_ffff;
      end
      if (a[31:21] == 11'h7f6) r.target = TGT_CFGADDR;
      if (a[31:20] == 12'hfee) r.target = TGT_CFGDATA;
      if (a[31:20] == 12'hfef) begin
        r.target = TGT_INTACK;
        r.transferErrorAck = w && teaEnable;
        r.writeDiscard = w && !teaEnable;
      end
      if (a[31:24] == 8'hff) begin
        r.target = TGT_ROM;
        r.romLocal = romCpu;
        r.romToPci = romPci;
        r.rom64Only = !a[23];
      end
    end
    return r;
  endfunction

  // Expected PCI-side claim
  function automatic hpd_pci_result_t exp_pci(logic [31:0] a, logic io);
    hpd_pci_result_t r;
    r = '0;
    r.sysAddr = a;
    if (io) r.ioReserved = !(a <= 32'h0000_ffff || a inside {[32'h0080_0000:32'h00bf_ffff]});
    else if (a[31:30] == 2'h0) r.claim = (a inside {[32'h000a_0000:32'h000f_ffff]}) ? pHole : 1'b1;
    else if (a[31:30] == 2'h1) begin
      r.claim = 1'b1;
      r.memSelErr = memSelErrEnable;
    end else if (a[31:24] == 8'hfd) begin
      r.claim = fdAlias;
      r.sysAddr = a & 32'h00ff_ffff;
    end else if (a[31:24] == 8'hff) begin
      r.toRom = 1'b1;
      r.claim = romCpu;
      r.rom64Only = !a[23];
    end
    return r;
  endfunction

  // Compare helpers; addresses only matter where something is forwarded
  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_cpu(input hpd_cpu_result_t g, input hpd_cpu_result_t e);
    if (!(e.target inside {TGT_PCIMEM, TGT_PCIIO, TGT_INTACK, TGT_ROM})) g.pciAddr = e.pciAddr;
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t cpu got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pci(input hpd_pci_result_t g, input hpd_pci_result_t e);
    if (!e.claim) g.sysAddr = e.sysAddr;
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t pci got %h exp %h", $time, g, e);
    end
  endtask

  // One request each side, checked in the answer cycle
  task automatic do_cpu(input logic [31:0] a, input logic w);
    BUS.cpu_cycle(a, w);
    chk_bit(cpuDone, 1'b1);
    chk_cpu(cpuRes, exp_cpu(a, w));
  endtask
  task automatic do_pci(input logic [31:0] a, input logic io);
    BUS.pci_cycle(a, io);
    chk_bit(pciDone, 1'b1);
    if (mapOn) chk_pci(pciRes, exp_pci(a, io));
    else chk_bit(pciRes.claim, 1'b0);
  endtask
  task automatic rand_cfg();
    {memSelErrEnable, teaEnable, cHole, pHole, fdAlias, ioSel, romCpu, romPci} = 8'($urandom);
  endtask
  task automatic sel_map(input logic v);
    mapSelWrite = 1'b1;
    mapSelValue = v;
    @(posedge clock);
    #1;
    mapSelWrite = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard, far beyond the under two thousand cycles expected
  initial begin
    #(40 * 20000);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    logic [31:0] a;
    int n;
    void'($urandom(32'h64ac));
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    sel_map(1'b1); // Too early to be taken
    n = 0;
    while (strapDone !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk_bit(strapDone, 1'b1);
    chk_bit(mapBActive, 1'b1);
    mapOn = 1'b1;
    $display("test strap select done");
    foreach (corner[i]) begin
      rand_cfg();
      do_cpu(corner[i], i[0]);
      do_pci(corner[i], 1'b0);
      do_pci(corner[i], 1'b1);
    end
    $display("test corners done");
    repeat (400) begin
      rand_cfg();
      a = $urandom;
      if (a[0]) a[31:24] = tops[$urandom % 8];
      if (a[1] && a[31:24] == 8'h00) a[23:20] = 4'h0;
      do_cpu(a, 1'($urandom));
      do_pci(a, 1'($urandom));
    end
    $display("test random decode done");
    sel_map(1'b1);
    mapOn = 1'b0;
    chk_bit(mapBActive, 1'b0);
    do_cpu(32'h0000_1000, 1'b0);
    do_pci(32'h0000_1000, 1'b0);
    sel_map(1'b0);
    mapOn = 1'b1;
    chk_bit(mapBActive, 1'b1);
    do_cpu(32'hfef0_0010, 1'b1);
    $display("test map select done");
    final_report();
  end
endmodule
